// ### logic/ppmux_pkg.sv
// Package with constants and carrier types of the parallel port pin mux.
package ppmux_pkg;
  localparam int PPMUX_DATA_W = 16;
  localparam logic PPMUX_STROBE_IDLE = 1'h1;
  localparam logic PPMUX_SEL_RESET = 1'h0;
  // Read strobe roles; the sync read enable role is selected by a bit.
  typedef enum logic [3:0] {
    PPMUX_RS_ASYNC_RE = 4'h1,
    PPMUX_RS_SYNC_ADS = 4'h2,
    PPMUX_RS_SD_CAS = 4'h4,
    PPMUX_RS_SYNC_RE = 4'h8
  } ppmux_rs_role_t;
  // Drive request of one pin: output value and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } ppmux_pin_drv_t;
  // Core-side request for one function: value and drive enable.
  typedef struct packed {
    logic [PPMUX_DATA_W-1:0] o;
    logic [PPMUX_DATA_W-1:0] oe;
  } ppmux_bus_drv_t;
endpackage

// ### logic/ppmux_top.sv
// Reset-time function selection of parallel port data and control pins.
`timescale 1ns/1ps
module ppmux_top
  import ppmux_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mode_strap_pin,
  input wire logic [PPMUX_DATA_W-1:0] pport_data_in,
  output logic [PPMUX_DATA_W-1:0] pport_data_out,
  output logic [PPMUX_DATA_W-1:0] pport_data_oe,
  input wire logic pport_ctrl_pin_a_in,
  output logic pport_ctrl_pin_a_out,
  output logic pport_ctrl_pin_a_oe,
  input wire logic pport_ctrl_pin_b_in,
  output logic pport_ctrl_pin_b_out,
  output logic pport_ctrl_pin_b_oe,
  input wire ppmux_bus_drv_t ext_mem_data_low_drv,
  output logic [PPMUX_DATA_W-1:0] ext_mem_data_low_in,
  input wire ppmux_bus_drv_t host_port_data_drv,
  output logic [PPMUX_DATA_W-1:0] host_port_data_in,
  input wire ppmux_pin_drv_t pport_gp_bit20_drv,
  output logic pport_gp_bit20_in,
  input wire ppmux_pin_drv_t pport_gp_bit21_drv,
  output logic pport_gp_bit21_in,
  input wire logic ext_mem_read_strobe_pin,
  input wire logic ext_mem_oe_row_strobe_pin,
  input wire ppmux_rs_role_t ext_mem_rs_role_req,
  input wire logic sync_read_enable_select,
  output ppmux_rs_role_t ext_mem_rs_role,
  output logic ext_mem_sel,
  output logic host_port_nonmux
);

  // All checks of this block run on the core clock and rest during reset.
  default clocking ppmux_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Strap synchroniser: three stages, a change counts when two agree.
  logic strap_s1, strap_s2, strap_s3, strap_seen;
  logic next_strap_seen;

  // Track the strap while reset is held; hold the last agreed value.
  always_comb
  begin
    next_strap_seen = strap_seen;
    if (strap_s2 == strap_s3)
      next_strap_seen = strap_s3;
  end

  // The strap is sampled on every rising edge; the synchroniser never resets.
  always_ff @(posedge core_clk)
  begin
    strap_s1 <= mode_strap_pin;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
    strap_seen <= next_strap_seen;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset release detection and the function select register.
  logic rst_q1, rst_q2, sel_lock, sel;
  logic next_sel_lock, next_sel;

  // The select follows the strap until the third edge after release.
  always_comb
  begin
    next_sel_lock = rst_q2;
    next_sel = sel;
    if (!sel_lock)
      next_sel = strap_seen;
  end

  // Async reset clears the select; the lock stays set until next reset.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q1 <= 1'h0;
      rst_q2 <= 1'h0;
      sel_lock <= 1'h0;
      sel <= PPMUX_SEL_RESET;
    end
    else
    begin
      rst_q1 <= 1'h1;
      rst_q2 <= rst_q1;
      sel_lock <= next_sel_lock;
      sel <= next_sel;
    end
  end

  // The pins come out of reset only once the select is frozen.
  logic active;
  assign active = sel_lock;
  assign ext_mem_sel = sel;
  assign host_port_nonmux = ~sel;

  ////////////////////////////////////////////////////////////////////////
  // Read strobe role: sync read enable only with the select bit set.
  always_comb
  begin
    ext_mem_rs_role = ext_mem_rs_role_req;
    if (ext_mem_rs_role_req == PPMUX_RS_SYNC_RE && !sync_read_enable_select)
      ext_mem_rs_role = PPMUX_RS_ASYNC_RE;
    else if (sync_read_enable_select)
      ext_mem_rs_role = PPMUX_RS_SYNC_RE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive registers; everything floats while reset is held.
  logic [PPMUX_DATA_W-1:0] next_d_out, next_d_oe;
  logic next_a_out, next_a_oe, next_b_out, next_b_oe;

  // Route the owner of each pin to its driver.
  always_comb
  begin
    next_d_out = '0;
    next_d_oe = '0;
    next_a_out = 1'h0;
    next_a_oe = 1'h0;
    next_b_out = 1'h0;
    next_b_oe = 1'h0;
    if (active && sel)
    begin
      next_d_out = ext_mem_data_low_drv.o;
      next_d_oe = ext_mem_data_low_drv.oe;
      next_a_out = ext_mem_read_strobe_pin;
      next_a_oe = 1'h1;
      next_b_out = ext_mem_oe_row_strobe_pin;
      next_b_oe = 1'h1;
    end
    else if (active)
    begin
      next_d_out = host_port_data_drv.o;
      next_d_oe = host_port_data_drv.oe;
      next_a_out = pport_gp_bit20_drv.o;
      next_a_oe = pport_gp_bit20_drv.oe;
      next_b_out = pport_gp_bit21_drv.o;
      next_b_oe = pport_gp_bit21_drv.oe;
    end
  end

  // Register the pin drivers; strobes start at their idle level.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pport_data_out <= '0;
      pport_data_oe <= '0;
      pport_ctrl_pin_a_out <= PPMUX_STROBE_IDLE;
      pport_ctrl_pin_a_oe <= 1'h0;
      pport_ctrl_pin_b_out <= PPMUX_STROBE_IDLE;
      pport_ctrl_pin_b_oe <= 1'h0;
    end
    else
    begin
      pport_data_out <= next_d_out;
      pport_data_oe <= next_d_oe;
      pport_ctrl_pin_a_out <= next_a_out;
      pport_ctrl_pin_a_oe <= next_a_oe;
      pport_ctrl_pin_b_out <= next_b_out;
      pport_ctrl_pin_b_oe <= next_b_oe;
    end
  end

  // Inputs from the pins go only to the function that owns them.
  assign ext_mem_data_low_in = sel ? pport_data_in : '0;
  assign host_port_data_in = sel ? '0 : pport_data_in;
  assign pport_gp_bit20_in = sel ? 1'h0 : pport_ctrl_pin_a_in;
  assign pport_gp_bit21_in = sel ? 1'h0 : pport_ctrl_pin_b_in;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_released;
    $rose(sel_lock);
  endsequence

  a_select_frozen: assert property (sel_lock && $past(sel_lock)
    |-> $stable(sel))
    else $error("Select changed after reset release.");

  a_strap_latched: assert property (s_released
    |-> sel == $past(strap_seen))
    else $error("Select does not match the strap at release.");

  a_reset_float: assert property (!active
    |=> !pport_ctrl_pin_a_oe && !pport_ctrl_pin_b_oe)
    else $error("Control pin driven before release.");

  a_read_strobe_on: assert property (active && sel
    |=> pport_ctrl_pin_a_oe)
    else $error("Read strobe pin not driven in memory mode.");

  a_row_strobe_on: assert property (active && sel
    |=> pport_ctrl_pin_b_oe)
    else $error("Row strobe pin not driven in memory mode.");

  a_gp20_input: assert property (active && !sel
    && !pport_gp_bit20_drv.oe |=> !pport_ctrl_pin_a_oe)
    else $error("GP bit 20 driven while requested as input.");

  a_gp21_input: assert property (active && !sel
    && !pport_gp_bit21_drv.oe |=> !pport_ctrl_pin_b_oe)
    else $error("GP bit 21 driven while requested as input.");

  a_mem_data_in: assert property (active && sel
    && ext_mem_data_low_drv.oe == '0 |=> pport_data_oe == '0)
    else $error("Memory data driven while requested as input.");

  a_host_data_in: assert property (active && !sel
    |=> pport_data_oe == $past(host_port_data_drv.oe))
    else $error("Host data enables not routed.");

  a_sre_select: assert property (ext_mem_rs_role == PPMUX_RS_SYNC_RE
    |-> sync_read_enable_select)
    else $error("Sync read enable without its select bit.");

  a_mem_data_route: assert property (active && sel
    |=> pport_data_out == $past(ext_mem_data_low_drv.o))
    else $error("Memory data not routed to the pins.");

  a_read_strobe_lvl: assert property (active && sel
    |=> pport_ctrl_pin_a_out == $past(ext_mem_read_strobe_pin))
    else $error("Read strobe level not routed to control pin A.");

  a_row_strobe_lvl: assert property (active && sel
    |=> pport_ctrl_pin_b_out == $past(ext_mem_oe_row_strobe_pin))
    else $error("Row strobe level not routed to control pin B.");

endmodule

// ### bench/ppmux_far_end.sv
// Far-side model of the memory or host device on the low data pins.
`timescale 1ns/1ps
module ppmux_far_end
  import ppmux_pkg::*;
(
  input wire logic core_clk,
  input wire logic [PPMUX_DATA_W-1:0] dev_out,
  input wire logic [PPMUX_DATA_W-1:0] dev_oe,
  input wire logic ext_en,
  input wire logic [PPMUX_DATA_W-1:0] ext_val,
  output logic [PPMUX_DATA_W-1:0] pin
);
  logic [PPMUX_DATA_W-1:0] last = '0;
  ////////////////////////////////////////////////////////////////////////
  // Released lines show ext_val while ext_en is set, else the inverse of their last level.
  always_comb
  begin
    for (int i = 0; i < PPMUX_DATA_W; i++)
      pin[i] = dev_oe[i] ? dev_out[i] : (ext_en ? ext_val[i] : ~last[i]);
  end
  // Remembers the resolved level of each line.
  always @(posedge core_clk)
    last <= pin;
endmodule

// ### bench/test_parallel_port_pin_mux.sv
// Self-checking bench of the parallel port pin mux.
`timescale 1ns/1ps
module test_parallel_port_pin_mux;
  import ppmux_pkg::*;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic strap = 1'h0;
  logic ext_en = 1'h0;
  logic a_in = 1'h0;
  logic b_in = 1'h1;
  logic rs_pin = 1'h1;
  logic oe_pin = 1'h1;
  logic rsel = 1'h0;
  logic [15:0] ext_val = 16'h5a3c;
  ppmux_rs_role_t role_req = PPMUX_RS_ASYNC_RE;
  ppmux_rs_role_t role;
  ppmux_rs_role_t roles [3] = '{PPMUX_RS_ASYNC_RE, PPMUX_RS_SYNC_ADS,
    PPMUX_RS_SD_CAS};
  ppmux_bus_drv_t mem_drv = '0;
  ppmux_bus_drv_t host_drv = '0;
  ppmux_pin_drv_t gp20 = '0;
  ppmux_pin_drv_t gp21 = '0;
  logic [15:0] pin, d_out, d_oe, mem_in, host_in;
  logic a_out, a_oe, b_out, b_oe, g20, g21, sel, nonmux;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns period.
  always #50 core_clk = ~core_clk;
  // Design and far side, joined through the low data pins.
  ppmux_top u_ppmux_top (.core_clk(core_clk), .rst_n(rst_n),
    .mode_strap_pin(strap), .pport_data_in(pin), .pport_data_out(d_out),
    .pport_data_oe(d_oe), .pport_ctrl_pin_a_in(a_in),
    .pport_ctrl_pin_a_out(a_out), .pport_ctrl_pin_a_oe(a_oe),
    .pport_ctrl_pin_b_in(b_in), .pport_ctrl_pin_b_out(b_out),
    .pport_ctrl_pin_b_oe(b_oe), .ext_mem_data_low_drv(mem_drv),
    .ext_mem_data_low_in(mem_in), .host_port_data_drv(host_drv),
    .host_port_data_in(host_in), .pport_gp_bit20_drv(gp20),
    .pport_gp_bit20_in(g20), .pport_gp_bit21_drv(gp21),
    .pport_gp_bit21_in(g21), .ext_mem_read_strobe_pin(rs_pin),
    .ext_mem_oe_row_strobe_pin(oe_pin), .ext_mem_rs_role_req(role_req),
    .sync_read_enable_select(rsel), .ext_mem_rs_role(role),
    .ext_mem_sel(sel), .host_port_nonmux(nonmux));
  ppmux_far_end u_ppmux_far_end (.core_clk(core_clk), .dev_out(d_out),
    .dev_oe(d_oe), .ext_en(ext_en), .ext_val(ext_val), .pin(pin));
  ////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a difference.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    if (seen !== exp)
      bad_count++;
  endtask
  // Prints the verdict and ends the run.
  task automatic results;
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reset of 10 cycles; the strap flips midway so only its last value counts.
  task automatic do_reset(input logic s);
    @(negedge core_clk);
    rst_n = 1'h0;
    strap = ~s;
    repeat (5) @(negedge core_clk);
    strap = s;
    repeat (5) @(negedge core_clk);
    check(a_oe, 1'h0);
    check(b_oe, 1'h0);
    rst_n = 1'h1;
    repeat (6) @(negedge core_clk);
  endtask
  // Memory mode: strobes idle high, data pins inputs, roles of read strobe.
  task automatic mem_mode;
    do_reset(1'h1);
    strap = 1'h0;
    ext_en = 1'h1;
    @(negedge core_clk);
    check(sel, 1'h1);
    check(nonmux, 1'h0);
    check({a_oe, a_out}, 2'h3);
    check({b_oe, b_out}, 2'h3);
    check(d_oe, 16'h0);
    check(mem_in, ext_val);
    rs_pin = 1'h0;
    oe_pin = 1'h0;
    mem_drv = {16'ha5c3, 16'hffff};
    @(negedge core_clk);
    check(a_out, 1'h0);
    check(b_out, 1'h0);
    check(pin, 16'ha5c3);
    for (int i = 0; i < 3; i++)
    begin
      role_req = roles[i];
      @(negedge core_clk);
      check(role, roles[i]);
    end
    role_req = PPMUX_RS_SYNC_RE;
    @(negedge core_clk);
    check(role, PPMUX_RS_ASYNC_RE);
    rsel = 1'h1;
    @(negedge core_clk);
    check(role, PPMUX_RS_SYNC_RE);
    check(sel, 1'h1);
    mem_drv = '0;
  endtask
  // Host mode: data pins to host port, control pins as GP inputs.
  task automatic host_mode;
    do_reset(1'h0);
    strap = 1'h1;
    a_in = 1'h1;
    b_in = 1'h0;
    @(negedge core_clk);
    check(sel, 1'h0);
    check(nonmux, 1'h1);
    check(host_in, ext_val);
    check(mem_in, 16'h0);
    check(a_oe, 1'h0);
    check(b_oe, 1'h0);
    check(g20, 1'h1);
    check(g21, 1'h0);
    host_drv = {16'h0f0f, 16'hffff};
    gp20 = 2'h3;
    gp21 = 2'h3;
    @(negedge core_clk);
    check(pin, 16'h0f0f);
    check({a_oe, a_out}, 2'h3);
    check({b_oe, b_out}, 2'h3);
    repeat (4) @(negedge core_clk);
    check(sel, 1'h0);
  endtask
  // Cuts a hang short.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      results();
    end
  end
  // Main sequence.
  initial
  begin
    mem_mode();
    host_mode();
    results();
  end
endmodule
